// File: common/fpam_defines.svh
`ifndef FPAM_DEFINES_SVH
`define FPAM_DEFINES_SVH

// ==========================================================
// timing
`define FPAM_CLK_NS 5
`define FPAM_SEC_NS 1000000000
`define FPAM_TICK_W 28

// ==========================================================
// value ranges, tenths of a percent of full_scale_span; delay limit in one-second ticks
`define FPAM_FLOW_LIM_MAX 11'h44c
`define FPAM_PRES_LO_MAX 10'h3e7
`define FPAM_PRES_HI_MIN 10'h001
`define FPAM_PRES_HI_MAX 10'h3e8
`define FPAM_DELAY_MAX 12'he10

// ==========================================================
// register byte offsets
`define FPAM_CTRL_OFS 8'h00
`define FPAM_FLOW_LIM_OFS 8'h04
`define FPAM_PRES_LIM_OFS 8'h08
`define FPAM_FLOW_DLY_OFS 8'h0c
`define FPAM_PRES_DLY_OFS 8'h10
`define FPAM_CLEAR_OFS 8'h14
`define FPAM_STATUS_OFS 8'h18

// ==========================================================
// control fields and reset values
`define FPAM_CTRL_FLOW_EN 0
`define FPAM_CTRL_FLOW_LATCH 1
`define FPAM_CTRL_VALVE_LSB 2
`define FPAM_CTRL_PRES_EN 4
`define FPAM_CTRL_PRES_LATCH 5
`define FPAM_CTRL_ASSIGN_LSB 8
`define FPAM_ASSIGN_RESET 4'hf
`define FPAM_HI_FIELD_LSB 16

`endif

// File: common/fpam_pkg.sv
`default_nettype none
package fpam_pkg;
  typedef enum logic [1:0] {
    VALVE_OFF,
    VALVE_ON_HIGH,
    VALVE_ON_LOW
  } fpam_valve_sel_t;

  typedef enum logic [1:0] {
    DISP_UNITS,
    DISP_LOW,
    DISP_HIGH
  } fpam_disp_t;

  typedef struct packed {
    logic enable;
    logic latch;
    logic [11:0] act_delay;
    logic [11:0] pon_delay;
  } fpam_chan_cfg_t;

  typedef struct packed {
    logic [11:0] flow;
    logic [11:0] setpoint;
    logic [10:0] pressure;
  } fpam_readings_t;
endpackage
`default_nettype wire

// File: sim/fpam_plant.sv
`default_nettype none
// ======
// sensor front end seen by the monitor
module fpam_plant import fpam_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [11:0] flow_cmd,
  input wire logic [11:0] sp_cmd,
  input wire logic [10:0] pres_cmd,
  output fpam_readings_t readings
);
  timeunit 1ns;
  timeprecision 100ps;
  // one sample per clock, like a converter
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      readings <= '0;
    end else begin
      readings <= '{flow: flow_cmd, setpoint: sp_cmd, pressure: pres_cmd};
    end
  end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`include "fpam_defines.svh"
`default_nettype none
module tb_top import fpam_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 20;
  logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, seed = 32'h0000000b;
  logic pready, pslverr, relay_output, valve_energize, err_bus;
  fpam_disp_t flow_display, pres_display;
  fpam_readings_t readings;
  logic [11:0] flow_cmd = '0, sp_cmd = '0;
  logic [10:0] pres_cmd = '0;
  int error_cnt = 0, n_compared = 0;
  fpam_top #(.TICK_CYCLES(TK)) dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .readings(readings), .relay_output(relay_output),
    .valve_energize(valve_energize), .flow_display(flow_display),
    .pres_display(pres_display));
  fpam_plant plant (.clk_sys(clk_sys), .reset(reset), .flow_cmd(flow_cmd), .sp_cmd(sp_cmd),
    .pres_cmd(pres_cmd), .readings(readings));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ======
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [1:0] f_exp(int f, int s, int lo, int hi);
    int d;
    d = (f > s) ? f - s : s - f;
    return {f > s && d >= hi, f < s && d >= lo};
  endfunction
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // bounded wait, the slave must answer before the limit
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err_bus = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic rdg(input int f, input int s, input int p);
    @(posedge clk_sys);
    flow_cmd <= f[11:0];
    sp_cmd <= s[11:0];
    pres_cmd <= p[10:0];
    cyc(4);
  endtask
  // warning and units must both show within a few ticks
  task automatic disp_chk(input logic pr, input fpam_disp_t w);
    int a, b;
    a = 0;
    b = 0;
    repeat (3 * TK) begin
      @(posedge clk_sys);
      if ((pr ? pres_display : flow_display) === w) a++;
      if ((pr ? pres_display : flow_display) === DISP_UNITS) b++;
    end
    chk("blink", {a > 0, b > 0}, 2'b11);
  endtask
  // ======
  // main sequence
  initial begin
    int f, s, lo, hi, n;
    logic [1:0] e;
    int pv[4] = '{99, 100, 900, 901};
    logic [1:0] pe[4] = '{2'b01, 2'b00, 2'b00, 2'b10};
    cyc(2);
    reset <= 1'b0;
    apb(0, `FPAM_CTRL_OFS, 0);
    chk("ctrl", rd, 32'h00000f00);
    apb(0, `FPAM_PRES_LIM_OFS, 0);
    chk("plim", rd, 32'h03e80000);
    apb(0, `FPAM_FLOW_DLY_OFS, 0);
    chk("fdly", rd, 32'h0);
    apb(0, 8'h1c, 0);
    chk("unmapped", rd, 32'h0);
    chk("slverr", err_bus, 1);
    apb(1, `FPAM_FLOW_LIM_OFS, 32'h07ff07ff);
    apb(0, `FPAM_FLOW_LIM_OFS, 0);
    chk("flim", rd, 32'h044c044c);
    apb(1, `FPAM_FLOW_DLY_OFS, 32'h00000fff);
    apb(0, `FPAM_FLOW_DLY_OFS, 0);
    chk("fdly", rd, 32'h00000e10);
    apb(1, `FPAM_PRES_DLY_OFS, 32'h0fff0fff);
    apb(0, `FPAM_PRES_DLY_OFS, 0);
    chk("pdly", rd, 32'h0e100e10);
    apb(1, `FPAM_PRES_DLY_OFS, 0);
    apb(1, `FPAM_FLOW_DLY_OFS, 0);
    apb(1, `FPAM_FLOW_LIM_OFS, 32'h01900190);
    rdg(100, 500, 0);
    apb(0, `FPAM_STATUS_OFS, 0);
    chk("off", {rd[3:0], relay_output}, 0);
    apb(1, `FPAM_CTRL_OFS, 32'h00000f05);
    for (int i = 0; i < 10; i++) begin
      f = (i == 0) ? 100 : (i == 1) ? 901 : int'(xs() % 1200);
      s = (i < 2) ? 500 : int'(xs() % 1200);
      lo = (i < 2) ? 400 : int'(xs() % 1101);
      hi = (i < 2) ? 401 : int'(xs() % 1101);
      apb(1, `FPAM_FLOW_LIM_OFS, {5'h0, hi[10:0], 5'h0, lo[10:0]});
      rdg(f, s, 0);
      apb(0, `FPAM_STATUS_OFS, 0);
      e = f_exp(f, s, lo, hi);
      chk("flow", rd[1:0], e);
      chk("relay", relay_output, |e);
      chk("valve", valve_energize, !e[1]);
    end
    apb(1, `FPAM_FLOW_LIM_OFS, 32'h01900190);
    // long power-on hold keeps the channel quiet
    apb(1, `FPAM_FLOW_DLY_OFS, 32'h0e100000);
    apb(1, `FPAM_CTRL_OFS, 32'h00000105);
    rdg(900, 500, 0);
    apb(0, `FPAM_STATUS_OFS, 0);
    chk("pon", {rd[6], rd[1:0]}, 3'b000);
    apb(1, `FPAM_FLOW_DLY_OFS, 0);
    rdg(900, 500, 0);
    // only the low event drives the relay here, the valve still acts
    chk("unassigned", {relay_output, valve_energize}, 2'b00);
    disp_chk(0, DISP_HIGH);
    apb(1, `FPAM_CTRL_OFS, 32'h00000f0b);
    rdg(100, 500, 0);
    chk("valve_lo", valve_energize, 0);
    disp_chk(0, DISP_LOW);
    apb(1, `FPAM_CTRL_OFS, 32'h00000f03);
    rdg(500, 500, 0);
    chk("latch", relay_output, 1);
    apb(1, `FPAM_CLEAR_OFS, 1);
    cyc(3);
    chk("clear", relay_output, 0);
    apb(1, `FPAM_CTRL_OFS, 32'h00000f01);
    apb(1, `FPAM_FLOW_DLY_OFS, 2);
    rdg(100, 500, 0);
    cyc(10);
    rdg(500, 500, 0);
    rdg(100, 500, 0);
    cyc(10);
    chk("delay", relay_output, 0);
    n = 0;
    while (relay_output !== 1'b1 && n < 80) begin
      @(posedge clk_sys);
      n++;
    end
    chk("delay_end", n < 80, 1);
    rdg(500, 500, 0);
    apb(1, `FPAM_CTRL_OFS, 32'h00000f10);
    // low limit kept under high limit
    apb(1, `FPAM_PRES_LIM_OFS, 32'h03840064);
    foreach (pv[i]) begin
      rdg(500, 500, pv[i]);
      apb(0, `FPAM_STATUS_OFS, 0);
      chk("pres", rd[3:2], pe[i]);
      chk("prelay", relay_output, |pe[i]);
    end
    rdg(500, 500, 50);
    disp_chk(1, DISP_LOW);
    apb(1, `FPAM_CTRL_OFS, 32'h00000f30);
    rdg(500, 500, 500);
    chk("platch", relay_output, 1);
    apb(1, `FPAM_CTRL_OFS, 32'h00000f00);
    cyc(3);
    chk("pdis", relay_output, 0);
    test_done();
  end
endmodule
`default_nettype wire

// File: verilog/fpam_channel.sv
`include "fpam_defines.svh"
`default_nettype none
module fpam_channel import fpam_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tick,
  input wire fpam_chan_cfg_t cfg,
  input wire logic clear,
  input wire logic cond_lo,
  input wire logic cond_hi,
  input wire logic [1:0] relay_assign,
  output logic alarm_lo,
  output logic alarm_hi,
  output logic relay,
  output logic pon_done
);
  logic [11:0] pon_cnt;
  logic [11:0] act_cnt;
  logic latched;
  logic armed;
  logic cond;
  logic qualified;
  logic evt;

  // ==========================================================
  // power-on hold-off, counted from reset release
  assign pon_done = pon_cnt >= cfg.pon_delay;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pon_cnt <= 12'h000;
    end else if (tick && pon_cnt < `FPAM_DELAY_MAX) begin
      pon_cnt <= pon_cnt + 12'h001;
    end
  end

  // ==========================================================
  // action delay; first second may be short, ticks are free running
  assign armed = cfg.enable & pon_done;
  assign cond = (cond_lo | cond_hi) & armed;
  assign qualified = cond && act_cnt >= cfg.act_delay;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      act_cnt <= 12'h000;
    end else if (!cond) begin
      act_cnt <= 12'h000;
    end else if (tick && act_cnt < cfg.act_delay) begin
      act_cnt <= act_cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      alarm_lo <= 1'b0;
      alarm_hi <= 1'b0;
    end else begin
      alarm_lo <= qualified & cond_lo;
      alarm_hi <= qualified & cond_hi;
    end
  end

  // ==========================================================
  // relay hold; a fresh event wins over a clear in the same cycle
  assign evt = |({alarm_hi, alarm_lo} & relay_assign);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      latched <= 1'b0;
    end else if (evt && cfg.latch) begin
      latched <= 1'b1;
    end else if (clear || !cfg.enable) begin
      latched <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      relay <= 1'b0;
    end else begin
      relay <= evt | (latched & cfg.latch);
    end
  end

  // ==========================================================
  property p_pon_hold;
    @(posedge clk_sys) disable iff (reset)
    !pon_done |=> !alarm_lo && !alarm_hi;
  endproperty
  a_pon_hold: assert property (p_pon_hold) else $error("alarm before power-on delay");

  property p_restart;
    @(posedge clk_sys) disable iff (reset)
    !cond |=> act_cnt == 12'h000;
  endproperty
  a_restart: assert property (p_restart) else $error("action count kept");

  property p_act_delay;
    @(posedge clk_sys) disable iff (reset)
    $rose(alarm_lo || alarm_hi) |-> $past(act_cnt >= cfg.act_delay && cond);
  endproperty
  a_act_delay: assert property (p_act_delay) else $error("alarm before delay");

  property p_latch_hold;
    @(posedge clk_sys) disable iff (reset)
    relay && latched && cfg.latch && cfg.enable && !clear ##1 cfg.latch |-> relay;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched relay dropped");

  property p_follow;
    @(posedge clk_sys) disable iff (reset)
    !cfg.latch |=> relay == $past(evt);
  endproperty
  a_follow: assert property (p_follow) else $error("relay not following alarm");
endmodule
`default_nettype wire

// File: verilog/fpam_top.sv
// The implementer's own choices: the APB register port and the register addresses.
`include "fpam_defines.svh"
`default_nettype none
module fpam_top import fpam_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `FPAM_SEC_NS / `FPAM_CLK_NS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fpam_readings_t readings,
  output logic relay_output,
  output logic valve_energize,
  output fpam_disp_t flow_display,
  output fpam_disp_t pres_display
);
  localparam logic [`FPAM_TICK_W-1:0] TICK_LAST = `FPAM_TICK_W'(TICK_CYCLES - 1);

  logic flow_en;
  logic flow_latch;
  logic pres_en;
  logic pres_latch;
  fpam_valve_sel_t valve_sel;
  logic [3:0] relay_assign;
  logic [10:0] flow_lo_lim;
  logic [10:0] flow_hi_lim;
  logic [9:0] pres_lo_lim;
  logic [9:0] pres_hi_lim;
  logic [11:0] flow_act;
  logic [11:0] flow_pon;
  logic [11:0] pres_act;
  logic [11:0] pres_pon;
  logic flow_clear;
  logic pres_clear;
  logic [`FPAM_TICK_W-1:0] tick_cnt;
  logic tick;
  logic [11:0] deviation;
  logic flow_lo_cond;
  logic flow_hi_cond;
  logic pres_lo_cond;
  logic pres_hi_cond;
  logic flow_lo_alarm;
  logic flow_hi_alarm;
  logic pres_lo_alarm;
  logic pres_hi_alarm;
  logic flow_relay;
  logic pres_relay;
  logic flow_pon_done;
  logic pres_pon_done;
  logic flow_phase;
  logic pres_phase;
  logic wr_en;
  logic mapped;
  logic [31:0] next_prdata;
  fpam_chan_cfg_t flow_cfg;
  fpam_chan_cfg_t pres_cfg;

  // ==========================================================
  // helpers
  function automatic logic [11:0] clamp12(input logic [11:0] v, input logic [11:0] lo,
                                          input logic [11:0] hi);
    if (v < lo) begin
      clamp12 = lo;
    end else if (v > hi) begin
      clamp12 = hi;
    end else begin
      clamp12 = v;
    end
  endfunction

  function automatic fpam_disp_t disp_code(input logic lo, input logic hi, input logic phase);
    if (hi && phase) begin
      disp_code = DISP_HIGH;
    end else if (lo && phase) begin
      disp_code = DISP_LOW;
    end else begin
      disp_code = DISP_UNITS;
    end
  endfunction

  // ==========================================================
  // one-second enable
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + `FPAM_TICK_W'(1);
    end
  end
  assign tick = tick_cnt == TICK_LAST;

  // ==========================================================
  // apb slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  always_comb begin
    mapped = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      `FPAM_CTRL_OFS: begin
        next_prdata[`FPAM_CTRL_FLOW_EN] = flow_en;
        next_prdata[`FPAM_CTRL_FLOW_LATCH] = flow_latch;
        next_prdata[`FPAM_CTRL_VALVE_LSB +: 2] = valve_sel;
        next_prdata[`FPAM_CTRL_PRES_EN] = pres_en;
        next_prdata[`FPAM_CTRL_PRES_LATCH] = pres_latch;
        next_prdata[`FPAM_CTRL_ASSIGN_LSB +: 4] = relay_assign;
      end
      `FPAM_FLOW_LIM_OFS: begin
        next_prdata[10:0] = flow_lo_lim;
        next_prdata[`FPAM_HI_FIELD_LSB +: 11] = flow_hi_lim;
      end
      `FPAM_PRES_LIM_OFS: begin
        next_prdata[9:0] = pres_lo_lim;
        next_prdata[`FPAM_HI_FIELD_LSB +: 10] = pres_hi_lim;
      end
      `FPAM_FLOW_DLY_OFS: begin
        next_prdata[11:0] = flow_act;
        next_prdata[`FPAM_HI_FIELD_LSB +: 12] = flow_pon;
      end
      `FPAM_PRES_DLY_OFS: begin
        next_prdata[11:0] = pres_act;
        next_prdata[`FPAM_HI_FIELD_LSB +: 12] = pres_pon;
      end
      `FPAM_CLEAR_OFS: begin
        next_prdata = 32'h0000_0000;
      end
      `FPAM_STATUS_OFS: begin
        next_prdata[11:0] = {pres_hi_cond, pres_lo_cond, flow_hi_cond, flow_lo_cond,
                             pres_pon_done, flow_pon_done, valve_energize, relay_output,
                             pres_hi_alarm, pres_lo_alarm, flow_hi_alarm, flow_lo_alarm};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // read data captured in the setup cycle, stable through the access phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flow_en <= 1'b0;
      flow_latch <= 1'b0;
      valve_sel <= VALVE_OFF;
      pres_en <= 1'b0;
      pres_latch <= 1'b0;
      relay_assign <= `FPAM_ASSIGN_RESET;
    end else if (wr_en && paddr == `FPAM_CTRL_OFS) begin
      flow_en <= pwdata[`FPAM_CTRL_FLOW_EN];
      flow_latch <= pwdata[`FPAM_CTRL_FLOW_LATCH];
      pres_en <= pwdata[`FPAM_CTRL_PRES_EN];
      pres_latch <= pwdata[`FPAM_CTRL_PRES_LATCH];
      relay_assign <= pwdata[`FPAM_CTRL_ASSIGN_LSB +: 4];
      // the unused fourth code falls back to no valve action
      case (pwdata[`FPAM_CTRL_VALVE_LSB +: 2])
        2'h1: valve_sel <= VALVE_ON_HIGH;
        2'h2: valve_sel <= VALVE_ON_LOW;
        default: valve_sel <= VALVE_OFF;
      endcase
    end
  end

  // out-of-range writes are clamped rather than refused
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flow_lo_lim <= 11'h000;
      flow_hi_lim <= 11'h000;
      pres_lo_lim <= 10'h000;
      pres_hi_lim <= `FPAM_PRES_HI_MAX;
    end else if (wr_en && paddr == `FPAM_FLOW_LIM_OFS) begin
      flow_lo_lim <= 11'(clamp12({1'b0, pwdata[10:0]}, 12'h000,
                                 {1'b0, `FPAM_FLOW_LIM_MAX}));
      flow_hi_lim <= 11'(clamp12({1'b0, pwdata[26:16]}, 12'h000,
                                 {1'b0, `FPAM_FLOW_LIM_MAX}));
    end else if (wr_en && paddr == `FPAM_PRES_LIM_OFS) begin
      pres_lo_lim <= 10'(clamp12({2'h0, pwdata[9:0]}, 12'h000,
                                 {2'h0, `FPAM_PRES_LO_MAX}));
      pres_hi_lim <= 10'(clamp12({2'h0, pwdata[25:16]}, {2'h0, `FPAM_PRES_HI_MIN},
                                 {2'h0, `FPAM_PRES_HI_MAX}));
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flow_act <= 12'h000;
      flow_pon <= 12'h000;
      pres_act <= 12'h000;
      pres_pon <= 12'h000;
    end else if (wr_en && paddr == `FPAM_FLOW_DLY_OFS) begin
      flow_act <= clamp12(pwdata[11:0], 12'h000, `FPAM_DELAY_MAX);
      flow_pon <= clamp12(pwdata[27:16], 12'h000, `FPAM_DELAY_MAX);
    end else if (wr_en && paddr == `FPAM_PRES_DLY_OFS) begin
      pres_act <= clamp12(pwdata[11:0], 12'h000, `FPAM_DELAY_MAX);
      pres_pon <= clamp12(pwdata[27:16], 12'h000, `FPAM_DELAY_MAX);
    end
  end

  assign flow_clear = wr_en && paddr == `FPAM_CLEAR_OFS && pwdata[0];
  assign pres_clear = wr_en && paddr == `FPAM_CLEAR_OFS && pwdata[1];

  // ==========================================================
  // limit comparisons
  assign deviation = (readings.flow >= readings.setpoint) ?
                     readings.flow - readings.setpoint :
                     readings.setpoint - readings.flow;
  assign flow_lo_cond = deviation >= {1'b0, flow_lo_lim} &&
                        readings.flow < readings.setpoint;
  assign flow_hi_cond = deviation >= {1'b0, flow_hi_lim} &&
                        readings.flow > readings.setpoint;
  assign pres_lo_cond = readings.pressure < {1'b0, pres_lo_lim};
  assign pres_hi_cond = readings.pressure > {1'b0, pres_hi_lim};

  // ==========================================================
  // channels
  assign flow_cfg = '{enable: flow_en, latch: flow_latch, act_delay: flow_act,
                      pon_delay: flow_pon};
  assign pres_cfg = '{enable: pres_en, latch: pres_latch, act_delay: pres_act,
                      pon_delay: pres_pon};

  fpam_channel u_flow (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(tick),
    .cfg(flow_cfg),
    .clear(flow_clear),
    .cond_lo(flow_lo_cond),
    .cond_hi(flow_hi_cond),
    .relay_assign(relay_assign[1:0]),
    .alarm_lo(flow_lo_alarm),
    .alarm_hi(flow_hi_alarm),
    .relay(flow_relay),
    .pon_done(flow_pon_done)
  );

  fpam_channel u_pres (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(tick),
    .cfg(pres_cfg),
    .clear(pres_clear),
    .cond_lo(pres_lo_cond),
    .cond_hi(pres_hi_cond),
    .relay_assign(relay_assign[3:2]),
    .alarm_lo(pres_lo_alarm),
    .alarm_hi(pres_hi_alarm),
    .relay(pres_relay),
    .pon_done(pres_pon_done)
  );

  // ==========================================================
  // outputs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      relay_output <= 1'b0;
    end else begin
      relay_output <= flow_relay | pres_relay;
    end
  end

  // valve closes while the alarm stands, not while only the relay is latched
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      valve_energize <= 1'b1;
    end else begin
      valve_energize <= !((valve_sel == VALVE_ON_HIGH && flow_hi_alarm) ||
                          (valve_sel == VALVE_ON_LOW && flow_lo_alarm));
    end
  end

  // warning shown first, then units, swapping on every one-second tick
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flow_phase <= 1'b1;
      pres_phase <= 1'b1;
    end else begin
      flow_phase <= !(flow_lo_alarm || flow_hi_alarm) ? 1'b1 : flow_phase ^ tick;
      pres_phase <= !(pres_lo_alarm || pres_hi_alarm) ? 1'b1 : pres_phase ^ tick;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flow_display <= DISP_UNITS;
      pres_display <= DISP_UNITS;
    end else begin
      flow_display <= disp_code(flow_lo_alarm, flow_hi_alarm, flow_phase);
      pres_display <= disp_code(pres_lo_alarm, pres_hi_alarm, pres_phase);
    end
  end

  // ==========================================================
  // checks
  property p_flow_lo_dir;
    @(posedge clk_sys) disable iff (reset)
    $rose(flow_lo_alarm) |-> $past(readings.flow < readings.setpoint && deviation >=
                                   {1'b0, flow_lo_lim});
  endproperty
  a_flow_lo_dir: assert property (p_flow_lo_dir) else $error("low flow wrong side");

  property p_flow_hi_dir;
    @(posedge clk_sys) disable iff (reset)
    $rose(flow_hi_alarm) |-> $past(readings.flow > readings.setpoint);
  endproperty
  a_flow_hi_dir: assert property (p_flow_hi_dir) else $error("high flow wrong side");

  property p_flow_immediate;
    @(posedge clk_sys) disable iff (reset)
    flow_en && flow_pon_done && flow_act == 12'h000 && flow_lo_cond |=> flow_lo_alarm;
  endproperty
  a_flow_immediate: assert property (p_flow_immediate) else $error("no flow alarm");

  property p_flow_off;
    @(posedge clk_sys) disable iff (reset)
    !flow_en ##1 !flow_en |-> !flow_lo_alarm && !flow_hi_alarm;
  endproperty
  a_flow_off: assert property (p_flow_off) else $error("flow alarm while disabled");

  property p_pres_off;
    @(posedge clk_sys) disable iff (reset)
    !pres_en ##1 !pres_en |-> !pres_lo_alarm && !pres_hi_alarm;
  endproperty
  a_pres_off: assert property (p_pres_off) else $error("pressure alarm while off");

  property p_limits;
    @(posedge clk_sys) disable iff (reset)
    flow_lo_lim <= `FPAM_FLOW_LIM_MAX && flow_hi_lim <= `FPAM_FLOW_LIM_MAX &&
    pres_lo_lim <= `FPAM_PRES_LO_MAX &&
    pres_hi_lim >= `FPAM_PRES_HI_MIN && pres_hi_lim <= `FPAM_PRES_HI_MAX;
  endproperty
  a_limits: assert property (p_limits) else $error("limit out of range");

  property p_pres_lo;
    @(posedge clk_sys) disable iff (reset)
    $rose(pres_lo_alarm) |-> $past(readings.pressure < {1'b0, pres_lo_lim});
  endproperty
  a_pres_lo: assert property (p_pres_lo) else $error("low pressure not below");

  property p_pres_hi;
    @(posedge clk_sys) disable iff (reset)
    $rose(pres_hi_alarm) |-> $past(readings.pressure > {1'b0, pres_hi_lim});
  endproperty
  a_pres_hi: assert property (p_pres_hi) else $error("high pressure not above");

  property p_valve;
    @(posedge clk_sys) disable iff (reset)
    valve_sel == VALVE_ON_HIGH && flow_hi_alarm |=> !valve_energize;
  endproperty
  a_valve: assert property (p_valve) else $error("valve not closed");

  property p_flow_disp;
    @(posedge clk_sys) disable iff (reset)
    flow_display != DISP_UNITS |-> $past(flow_lo_alarm || flow_hi_alarm);
  endproperty
  a_flow_disp: assert property (p_flow_disp) else $error("flow warning without alarm");
endmodule
`default_nettype wire
